// ===== rtl/swsc_defines.svh
/*
  Offsets, reset values, field positions and timing counts of the slave watchdog and state control block.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef SWSC_DEFINES_SVH
`define SWSC_DEFINES_SVH

// Register byte offsets
`define SWSC_OFF_PRESCALER     12'h400
`define SWSC_OFF_LOCAL_TIME    12'h410
`define SWSC_OFF_XFER_TIME     12'h420
`define SWSC_OFF_CONTROL       12'h430
`define SWSC_OFF_STATE_REQ     12'h434
`define SWSC_OFF_STATUS        12'h438
`define SWSC_OFF_OUT_DATA      12'h43C
`define SWSC_OFF_SAFE_DATA     12'h440
`define SWSC_OFF_IN_SNAP       12'h444

// Reset values
`define SWSC_RST_PRESCALER     16'h09C2
`define SWSC_RST_LOCAL_TIME    16'h03E8
`define SWSC_RST_XFER_TIME     16'h03E8
`define SWSC_RST_CONTROL       8'h07

// Control register field positions
`define SWSC_CTL_XFER_EN       0
`define SWSC_CTL_LOCAL_EN      1
`define SWSC_CTL_SUPERVISE     2
`define SWSC_CTL_MBX_OK        3
`define SWSC_CTL_PD_OK         4
`define SWSC_CTL_SYNC_OK       5

// Status register field positions
`define SWSC_STS_STATE_LSB     0
`define SWSC_STS_XFER_TRIG     4
`define SWSC_STS_LOCAL_TRIG    5
`define SWSC_STS_REFUSED       6
`define SWSC_STS_PD_ALLOW      8
`define SWSC_STS_MBX_ALLOW     9
`define SWSC_STS_FILE_ONLY     10

// Base clock of the watchdog ticks, and the system clock
`define SWSC_BASE_PERIOD_NS    40
`define SWSC_CLK_PERIOD_NS     50
// Extra base periods added to the prescaler per tick
`define SWSC_TICK_EXTRA        2

`endif

// ===== rtl/swsc_pkg.sv
/*
  Types of the slave watchdog and state control block.
  Assumes the defines header is on the include path.
*/
package swsc_pkg;
  `include "swsc_defines.svh"

  // Slave life-cycle states
  typedef enum logic [3:0] {
    SWSC_POWER_ON      = 4'b0001,
    SWSC_MAILBOX_ONLY  = 4'b0010,
    SWSC_FIRMWARE_UPD  = 4'b0011,
    SWSC_INPUTS_ONLY   = 4'b0100,
    SWSC_FULL_RUN      = 4'b1000
  } swsc_state_type;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } swsc_apb_req_type;

  // APB answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } swsc_apb_rsp_type;

  // Whole state of the block
  typedef struct packed {
    logic [15:0]    prescaler;
    logic [15:0]    local_time;
    logic [15:0]    xfer_time;
    logic [7:0]     control;
    logic [31:0]    out_data;
    logic [31:0]    safe_data;
    logic [31:0]    in_snap;
    logic [31:0]    phys_out;
    logic [31:0]    prdata;
    logic           pslverr;
    swsc_state_type state;
    logic           refused;
    logic [16:0]    base_cnt;
    logic           tick;
    logic [15:0]    xfer_cnt;
    logic [15:0]    local_cnt;
    logic           xfer_trig;
    logic           local_trig;
    logic [1:0]     pd_sync;
    logic [1:0]     lpi_sync;
    logic           pd_seen;
    logic           lpi_seen;
    logic [1:0]     base_acc;
    logic           ack_due;
  } swsc_regs_type;
endpackage

// ===== rtl/swsc_top.sv
/*
  Slave watchdog and state control: two timeout watchdogs sharing a prescaler, output safe-state forcing,
  the five-state slave life-cycle machine, and an APB register slave.
  Assumes a 20 MHz clk, a master that keeps APB signalling, and access strobes that come from pins and are
  therefore synchronised here.
*/
`timescale 1ns/100ps
`include "swsc_defines.svh"

// Operation
// (RULE1) Expired watchdog forces outputs to safe value
// (RULE2) Two independent watchdogs, default 100 ms each
// (RULE3) Shared prescaler register at 0x400
// (RULE4) Own tick counts at 0x410 and 0x420
// (RULE5) Process data access restarts, clears transfer watchdog
// (RULE6) Enabled transfer watchdog triggers after timeout
// (RULE7) Transfer trigger leaves life-cycle state unchanged
// (RULE8) Enabled local watchdog triggers after timeout
// (RULE9) Tick is prescaler plus two base periods
// (RULE10) Transfer tick count zero disables that watchdog
// (RULE11) Five states, transitions requested by master
// (RULE12) Power-on state rejects mailbox and process data
// (RULE13) Master configures channels 0, 1 in power-on
// (RULE14) Check mailbox setup before entering mailbox-only
// (RULE15) Mailbox-only allows mailbox, refuses process data
// (RULE16) Master configures process data channels from 2
// (RULE17) Check channels, sync; snapshot inputs first
// (RULE18) Inputs-only exchanges data, outputs held safe
// (RULE19) Supervision off lets outputs follow commands
// (RULE20) Master writes valid outputs before full-run
// (RULE21) Full-run copies master outputs to pins
// (RULE22) Firmware-update only from power-on, file traffic
// (RULE23) Failed checks refuse, keep and report state
module swsc_top
  import swsc_pkg::*;
#(
  parameter int OUT_WIDTH = 32
) (
  input  wire logic             clk,            // 20 MHz system clock
  input  wire logic             rst,            // Asynchronous reset, active high
  input  wire swsc_apb_req_type apb_req,        // APB request
  output swsc_apb_rsp_type      apb_rsp,        // APB answer
  input  wire logic             pd_access,      // Successful bus-side process data access strobe (pin)
  input  wire logic             lpi_access,     // Local process interface access strobe (pin)
  input  wire logic [31:0]      phys_in,        // Current physical inputs, same clock domain
  output logic [31:0]           phys_out,       // Physical outputs
  output logic                  pd_allowed,     // Process data exchange permitted
  output logic                  mbx_allowed,    // Mailbox exchange permitted
  output logic                  file_only,      // Only file-transfer mailbox traffic permitted
  output logic                  xfer_expired,   // Transfer watchdog triggered
  output logic                  local_expired   // Local interface watchdog triggered
);

  // Elaboration check on the output width
  if (OUT_WIDTH < 1 || OUT_WIDTH > 32) begin : g_chk
    $error("swsc_top: OUT_WIDTH must be 1 to 32");
  end

  swsc_regs_type r_q;                           // Registered state
  swsc_regs_type r_d;                           // Next state

  // True for a legal requested move from the current state
  function automatic logic swsc_move_ok(input swsc_state_type cur, input swsc_state_type req,
                                        input logic [7:0] ctl);
    logic ok;
    ok = 1'b0;
    case (req)
      SWSC_POWER_ON:     ok = 1'b1;
      SWSC_MAILBOX_ONLY: ok = (cur == SWSC_MAILBOX_ONLY) ||
                              ((cur == SWSC_POWER_ON) && ctl[`SWSC_CTL_MBX_OK]) ||  // [RULE14]
                              (cur == SWSC_INPUTS_ONLY) || (cur == SWSC_FULL_RUN);
      SWSC_INPUTS_ONLY:  ok = (cur == SWSC_INPUTS_ONLY) || (cur == SWSC_FULL_RUN) ||
                              ((cur == SWSC_MAILBOX_ONLY) && ctl[`SWSC_CTL_PD_OK] &&
                               ctl[`SWSC_CTL_SYNC_OK]);                            // [RULE17]
      SWSC_FULL_RUN:     ok = (cur == SWSC_INPUTS_ONLY) || (cur == SWSC_FULL_RUN);
      SWSC_FIRMWARE_UPD: ok = (cur == SWSC_POWER_ON) || (cur == SWSC_FIRMWARE_UPD); // [RULE22]
      default:           ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Register read mux
  function automatic logic [31:0] swsc_read(input swsc_regs_type s, input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == `SWSC_OFF_PRESCALER) begin
      v = {16'h0000, s.prescaler};
    end else if (a == `SWSC_OFF_LOCAL_TIME) begin
      v = {16'h0000, s.local_time};
    end else if (a == `SWSC_OFF_XFER_TIME) begin
      v = {16'h0000, s.xfer_time};
    end else if (a == `SWSC_OFF_CONTROL) begin
      v = {24'h00_0000, s.control};
    end else if (a == `SWSC_OFF_STATE_REQ || a == `SWSC_OFF_STATUS) begin
      v = {21'h00_0000, s.state == SWSC_FIRMWARE_UPD,
           s.state != SWSC_POWER_ON,
           (s.state == SWSC_INPUTS_ONLY) || (s.state == SWSC_FULL_RUN),
           1'b0, s.refused, s.local_trig, s.xfer_trig, s.state};                   // [RULE23]
    end else if (a == `SWSC_OFF_OUT_DATA) begin
      v = s.out_data;
    end else if (a == `SWSC_OFF_SAFE_DATA) begin
      v = s.safe_data;
    end else if (a == `SWSC_OFF_IN_SNAP) begin
      v = s.in_snap;
    end
    return v;
  endfunction

  // True when the offset is mapped
  function automatic logic swsc_mapped(input logic [11:0] a);
    return (a == `SWSC_OFF_PRESCALER) || (a == `SWSC_OFF_LOCAL_TIME) || (a == `SWSC_OFF_XFER_TIME) ||
           (a == `SWSC_OFF_CONTROL) || (a == `SWSC_OFF_STATE_REQ) || (a == `SWSC_OFF_STATUS) ||
           (a == `SWSC_OFF_OUT_DATA) || (a == `SWSC_OFF_SAFE_DATA) || (a == `SWSC_OFF_IN_SNAP);
  endfunction

  // Next-state logic of the whole block
  always_comb begin
    logic           acc;
    logic           wr;
    logic [16:0]    tick_len;
    logic [16:0]    base_sum;
    logic [2:0]     acc_sum;
    logic           xfer_on;
    logic           local_on;
    logic           safe_force;
    swsc_state_type req;
    r_d      = r_q;
    acc      = apb_req.psel && apb_req.penable;
    // A write lands only at the edge that completes the access
    wr       = acc && r_q.ack_due && apb_req.pwrite && swsc_mapped(apb_req.paddr);
    req      = swsc_state_type'(apb_req.pwdata[3:0]);
    tick_len = 17'(r_q.prescaler) + 17'(`SWSC_TICK_EXTRA);                        // [RULE9]
    r_d.tick = 1'b0;

    // Pin strobes pass two flip-flops; only the second stage is read
    r_d.pd_sync  = {r_q.pd_sync[0], pd_access};
    r_d.lpi_sync = {r_q.lpi_sync[0], lpi_access};
    r_d.pd_seen  = r_q.pd_sync[1];
    r_d.lpi_seen = r_q.lpi_sync[1];

    // Base clock emulation: 50 ns clock accrues 40 ns base periods (5 per 4 at 25 MHz vs 20 MHz)
    acc_sum = {1'b0, r_q.base_acc} + 3'd1;
    base_sum = r_q.base_cnt + (acc_sum[2] ? 17'd2 : 17'd1);
    r_d.base_acc = acc_sum[1:0];
    // One or two base periods pass per system clock; count them toward a tick
    if (base_sum >= tick_len) begin
      // Keep the overshoot so no base period is lost; a stale count after a prescaler cut restarts
      r_d.base_cnt = ((base_sum - tick_len) < tick_len) ? (base_sum - tick_len) : 17'd0;
      r_d.tick     = 1'b1;                                                         // [RULE3]
    end else begin
      r_d.base_cnt = base_sum;
    end

    // Transfer watchdog
    xfer_on = r_q.control[`SWSC_CTL_XFER_EN] && (r_q.xfer_time != 16'h0000);      // [RULE10]
    if (!xfer_on) begin
      r_d.xfer_cnt  = 16'h0000;
      r_d.xfer_trig = 1'b0;
    end else if (r_q.pd_sync[1] && !r_q.pd_seen) begin
      r_d.xfer_cnt  = 16'h0000;                                                    // [RULE5]
      r_d.xfer_trig = 1'b0;
    end else if (r_q.tick && !r_q.xfer_trig) begin
      r_d.xfer_cnt = r_q.xfer_cnt + 16'd1;
      if (r_q.xfer_cnt + 16'd1 >= r_q.xfer_time) begin
        r_d.xfer_trig = 1'b1;                                                      // [RULE6] [RULE4]
      end
    end

    // Local interface watchdog, a zero count also keeps it idle
    local_on = r_q.control[`SWSC_CTL_LOCAL_EN] && (r_q.local_time != 16'h0000);   // [RULE2]
    if (!local_on) begin
      r_d.local_cnt  = 16'h0000;
      r_d.local_trig = 1'b0;
    end else if (r_q.lpi_sync[1] && !r_q.lpi_seen) begin
      r_d.local_cnt  = 16'h0000;
      r_d.local_trig = 1'b0;
    end else if (r_q.tick && !r_q.local_trig) begin
      r_d.local_cnt = r_q.local_cnt + 16'd1;
      if (r_q.local_cnt + 16'd1 >= r_q.local_time) begin
        r_d.local_trig = 1'b1;                                                     // [RULE8] [RULE4]
      end
    end

    // APB read data and error for this access
    // First access cycle captures the answer, the second presents it from flip-flops
    r_d.ack_due = acc && !r_q.ack_due;
    r_d.prdata  = (acc && !apb_req.pwrite && !r_q.ack_due) ? swsc_read(r_q, apb_req.paddr) : r_q.prdata;
    r_d.pslverr = acc && !r_q.ack_due && !swsc_mapped(apb_req.paddr);

    // APB writes
    if (wr) begin
      if (apb_req.paddr == `SWSC_OFF_PRESCALER) begin
        r_d.prescaler = apb_req.pwdata[15:0];                                      // [RULE3]
      end else if (apb_req.paddr == `SWSC_OFF_LOCAL_TIME) begin
        r_d.local_time = apb_req.pwdata[15:0];                                     // [RULE4]
      end else if (apb_req.paddr == `SWSC_OFF_XFER_TIME) begin
        r_d.xfer_time = apb_req.pwdata[15:0];                                      // [RULE4]
      end else if (apb_req.paddr == `SWSC_OFF_CONTROL) begin
        r_d.control = {2'b00, apb_req.pwdata[5:0]};
      end else if (apb_req.paddr == `SWSC_OFF_OUT_DATA) begin
        r_d.out_data = apb_req.pwdata;
      end else if (apb_req.paddr == `SWSC_OFF_SAFE_DATA) begin
        r_d.safe_data = apb_req.pwdata;
      end else if (apb_req.paddr == `SWSC_OFF_STATE_REQ) begin
        // Master requests a move; watchdog triggers never move the state
        if (swsc_move_ok(r_q.state, req, r_q.control)) begin                      // [RULE11] [RULE7]
          r_d.state   = req;
          r_d.refused = 1'b0;
          if (r_q.state == SWSC_MAILBOX_ONLY && req == SWSC_INPUTS_ONLY) begin
            r_d.in_snap = phys_in;                                                 // [RULE17]
          end
        end else begin
          r_d.refused = 1'b1;                                                      // [RULE23]
        end
      end
    end

    // Cyclic input update while process data runs
    if ((r_q.state == SWSC_INPUTS_ONLY || r_q.state == SWSC_FULL_RUN) &&
        !(wr && apb_req.paddr == `SWSC_OFF_STATE_REQ)) begin
      r_d.in_snap = phys_in;                                                       // [RULE18]
    end

    // Output selection
    safe_force = r_q.control[`SWSC_CTL_SUPERVISE] && (r_q.xfer_trig || r_q.local_trig);
    if (r_q.state == SWSC_FULL_RUN && !safe_force) begin
      r_d.phys_out = r_q.out_data;                                                 // [RULE21]
    end else if (r_q.state == SWSC_INPUTS_ONLY && !r_q.control[`SWSC_CTL_SUPERVISE]) begin
      r_d.phys_out = r_q.out_data;                                                 // [RULE19]
    end else begin
      r_d.phys_out = r_q.safe_data;                                                // [RULE1] [RULE18]
    end
    if (OUT_WIDTH < 32) begin
      r_d.phys_out = r_d.phys_out & ((32'h0000_0001 << OUT_WIDTH) - 32'h0000_0001);
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_q            <= '0;
      r_q.prescaler  <= `SWSC_RST_PRESCALER;                                      // [RULE2]
      r_q.local_time <= `SWSC_RST_LOCAL_TIME;
      r_q.xfer_time  <= `SWSC_RST_XFER_TIME;
      r_q.control    <= `SWSC_RST_CONTROL;
      r_q.state      <= SWSC_POWER_ON;                                             // [RULE12]
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs
  // One wait state per access; idle bus sees ready high
  assign apb_rsp.pready  = !(apb_req.psel && apb_req.penable) || r_q.ack_due;
  assign apb_rsp.pslverr = r_q.pslverr;
  assign apb_rsp.prdata  = r_q.prdata;
  assign phys_out        = r_q.phys_out;
  // Exchange permissions per state
  assign pd_allowed      = (r_q.state == SWSC_INPUTS_ONLY) || (r_q.state == SWSC_FULL_RUN); // [RULE15] [RULE12]
  assign mbx_allowed     = (r_q.state != SWSC_POWER_ON);                            // [RULE12] [RULE15]
  assign file_only       = (r_q.state == SWSC_FIRMWARE_UPD);                        // [RULE22]
  assign xfer_expired    = r_q.xfer_trig;
  assign local_expired   = r_q.local_trig;

endmodule

// ===== testbench/swsc_chk.sv
/* Port checker for swsc_top: watchdog and life-cycle properties.
   Assumes binding to swsc_top and the swsc_pkg types. */
`timescale 1ns/100ps
module swsc_chk
  import swsc_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst,
  input wire swsc_apb_req_type apb_req,
  input wire swsc_apb_rsp_type apb_rsp,
  input wire logic             pd_access,
  input wire logic             lpi_access,
  input wire logic [31:0]      phys_in,
  input wire logic [31:0]      phys_out,
  input wire logic             pd_allowed,
  input wire logic             mbx_allowed,
  input wire logic             file_only,
  input wire logic             xfer_expired,
  input wire logic             local_expired
);
  logic [7:0]  ctl_q;   // Shadow of the control register
  logic [15:0] xt_q;    // Shadow of the transfer tick count
  logic [15:0] lt_q;    // Shadow of the local tick count
  logic [31:0] safe_q;  // Shadow of the safe output value
  logic        wr;      // Write taken at this edge
  logic        xon;     // Transfer watchdog armed
  logic        lon;     // Local watchdog armed
  assign wr  = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
  assign xon = ctl_q[0] && (xt_q != 16'h0000);
  assign lon = ctl_q[1] && (lt_q != 16'h0000);
  // Follow the writes that the properties depend on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_q  <= 8'h07;
      xt_q   <= 16'h03E8;
      lt_q   <= 16'h03E8;
      safe_q <= 32'h00000000;
    end else if (wr) begin
      case (apb_req.paddr)
        12'h430: ctl_q  <= apb_req.pwdata[7:0];
        12'h420: xt_q   <= apb_req.pwdata[15:0];
        12'h410: lt_q   <= apb_req.pwdata[15:0];
        12'h440: safe_q <= apb_req.pwdata;
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_PWR_ON: assert property (!mbx_allowed |-> !pd_allowed && !file_only)
    else $error("power-on state allows exchange");
  AST_PD_MODE: assert property (pd_allowed |-> mbx_allowed && !file_only)
    else $error("process data allowed in wrong state");
  AST_FILE_ENTRY: assert property ($rose(file_only) |-> $past(!mbx_allowed))
    else $error("firmware state entered from wrong state");
  AST_STATE_KEEP: assert property ($rose(xfer_expired) && !wr |=> $stable({pd_allowed, mbx_allowed, file_only}))
    else $error("trigger changed life-cycle state");
  AST_SAFE_OUT: assert property ($past(xfer_expired && ctl_q[2]) |-> phys_out == $past(safe_q))
    else $error("outputs not safe after trigger");
  AST_XFER_OFF: assert property (!xon && $past(!xon) |-> !xfer_expired)
    else $error("disabled transfer watchdog triggered");
  AST_LOCAL_OFF: assert property (!lon && $past(!lon) |-> !local_expired)
    else $error("disabled local watchdog triggered");
  AST_XFER_CLEAR: assert property ($rose(pd_access) |-> ##[1:4] !xfer_expired)
    else $error("access did not clear transfer watchdog");
  AST_LOCAL_CLEAR: assert property ($rose(lpi_access) |-> ##[1:4] !local_expired)
    else $error("access did not clear local watchdog");
endmodule

bind swsc_top swsc_chk chk_u (.clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .pd_access(pd_access), .lpi_access(lpi_access), .phys_in(phys_in), .phys_out(phys_out),
  .pd_allowed(pd_allowed), .mbx_allowed(mbx_allowed), .file_only(file_only),
  .xfer_expired(xfer_expired), .local_expired(local_expired));

// ===== testbench/swsc_master_model.sv
/* Fieldbus master stand-in: makes process-data access strobes.
   Assumes the block's clock; run gates the traffic. */
`timescale 1ns/100ps
module swsc_master_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      pd_access
);
  logic [2:0] cnt_q;  // Access spacing counter
  // One access every eight clocks while run is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q     <= 3'h0;
      pd_access <= 1'b0;
    end else begin
      cnt_q     <= cnt_q + 3'h1;
      pd_access <= run && (cnt_q == 3'h0);
    end
  end
endmodule

// ===== testbench/testbench.sv
/* Self-checking bench for swsc_top over APB.
   Assumes the master model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
module testbench
  import swsc_pkg::*;
();
  localparam logic [31:0] OUT_V  = 32'h5A5A0F0F;  // Commanded outputs
  localparam logic [31:0] SAFE_V = 32'h000000C3;  // Safe outputs
  localparam logic [31:0] IN_V   = 32'h1234ABCD;  // Physical inputs
  logic             clk, rst, run, lpi, pd_access;
  logic             pd_allowed, mbx_allowed, file_only, xfer_expired, local_expired;
  logic [31:0]      phys_in, phys_out;
  swsc_apb_req_type req;
  swsc_apb_rsp_type rsp;
  int               err_total, comparisons, since_pd;
  swsc_top dut_u (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .pd_access(pd_access),
    .lpi_access(lpi), .phys_in(phys_in), .phys_out(phys_out), .pd_allowed(pd_allowed),
    .mbx_allowed(mbx_allowed), .file_only(file_only), .xfer_expired(xfer_expired),
    .local_expired(local_expired));
  swsc_master_model master_u (.clk(clk), .rst(rst), .run(run), .pd_access(pd_access));
  always #25 clk = ~clk;
  // Clocks since the last access strobe
  always @(posedge clk) since_pd <= pd_access ? 0 : since_pd + 1;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (rsp.pready !== 1'b1 && n < 16);
    check("pready", {31'h0, rsp.pready}, 32'h1);
    check("pslverr", {31'h0, rsp.pslverr},
      {31'h0, !(a inside {12'h400, 12'h410, 12'h420, 12'h430, 12'h434, 12'h438, 12'h43C, 12'h440, 12'h444})});
    r = rsp.prdata;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check($sformatf("read %h", a), r & m, exp);
  endtask
  // Set the configuration flags, request a state, check status and permissions
  task automatic req_state(input logic [7:0] c, input logic [3:0] s, input logic [31:0] st, input logic [31:0] fl);
    wr(12'h430, {24'h0, c});
    wr(12'h434, {28'h0, s});
    rd(12'h438, st, 32'h4F);
    check("flags", {29'h0, file_only, mbx_allowed, pd_allowed}, fl);
  endtask
  task automatic wait_lvl(input logic sel, input logic lvl);
    int n;
    n = 0;
    while ((sel ? local_expired : xfer_expired) !== lvl && n < 300) begin @(posedge clk); n++; end
    check("wait", {31'h0, n < 300}, 32'h1);
  endtask
  task automatic lpi_pulse();
    @(posedge clk);
    lpi <= 1'b1;
    @(posedge clk);
    lpi <= 1'b0;
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    stop_test();
  end
  // Main sequence
  initial begin
    clk = 0; rst = 1; run = 0; lpi = 0; phys_in = IN_V; req = '0; err_total = 0; comparisons = 0; since_pd = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    run <= 1'b1;
    rd(12'h400, 32'h09C2, 32'hFFFFFFFF);
    rd(12'h410, 32'h03E8, 32'hFFFFFFFF);
    rd(12'h420, 32'h03E8, 32'hFFFFFFFF);
    rd(12'h4F0, 32'h0, 32'hFFFFFFFF);
    req_state(8'h07, 4'h2, 32'h41, 32'h0);
    req_state(8'h0F, 4'h2, 32'h02, 32'h2);
    req_state(8'h0F, 4'h3, 32'h42, 32'h2);
    req_state(8'h0F, 4'h4, 32'h42, 32'h2);
    wr(12'h43C, OUT_V);
    wr(12'h440, SAFE_V);
    req_state(8'h3F, 4'h4, 32'h04, 32'h3);
    rd(12'h444, IN_V, 32'hFFFFFFFF);
    check("phys_out", phys_out, SAFE_V);
    req_state(8'h3D, 4'h8, 32'h08, 32'h3);
    check("phys_out", phys_out, OUT_V);
    for (int k = 0; k < 2; k++) begin
      wr(12'h400, 32'(3 * k));
      wr(12'h420, 32'h000A);
      run <= 1'b0;
      wait_lvl(1'b0, 1'b1);
      // since_pd lags the clocks elapsed from the strobe by one
      check("expiry", {31'h0, since_pd + 1 >= 8 * (3 * k + 2) && since_pd + 1 <= 8 * (3 * k + 2) + 6}, 32'h1);
      rd(12'h438, 32'h08, 32'h0F);
      check("phys_out", phys_out, SAFE_V);
      run <= 1'b1;
      wait_lvl(1'b0, 1'b0);
      repeat (2) @(posedge clk);
      check("phys_out", phys_out, OUT_V);
    end
    wr(12'h420, 32'h0);
    run <= 1'b0;
    repeat (60) @(posedge clk);
    check("xfer_expired", {31'h0, xfer_expired}, 32'h0);
    run <= 1'b1;
    wr(12'h410, 32'h0005);
    wr(12'h430, 32'h3F);
    lpi_pulse();
    wait_lvl(1'b1, 1'b1);
    check("xfer_expired", {31'h0, xfer_expired}, 32'h0);
    lpi_pulse();
    wait_lvl(1'b1, 1'b0);
    // Local watchdog off from here so it cannot re-trigger into the status reads
    req_state(8'h39, 4'h4, 32'h04, 32'h3);
    check("phys_out", phys_out, OUT_V);
    req_state(8'h39, 4'h1, 32'h01, 32'h0);
    req_state(8'h39, 4'h3, 32'h03, 32'h6);
    stop_test();
  end
endmodule
